//--- design/scrb_consts.vh
// Purpose: Offsets, field positions and reset values of the alignment and
//          clock control register bank
// Assumes: 8-bit register port with 16-bit byte addresses
// Notes:   Definitions only
`ifndef SCRB_CONSTS_VH
`define SCRB_CONSTS_VH
`define SCRB_ADDR_W            16
`define SCRB_DATA_W            8
`define SCRB_OFF_ALIGN_CTRL    16'h0029
`define SCRB_OFF_CLK_IN_CTRL   16'h002a
`define SCRB_OFF_SUPPLY_CTRL   16'h002b
`define SCRB_OFF_POS_LO        16'h002c
`define SCRB_OFF_POS_MID       16'h002d
`define SCRB_OFF_POS_HI        16'h002e
`define SCRB_RST_ALIGN_CTRL    8'h80
`define SCRB_RST_CLK_IN_CTRL   8'h00
`define SCRB_RST_SUPPLY_CTRL   8'h10
`define SCRB_BIT_PROC_EN       6
`define SCRB_BIT_RECV_EN       5
`define SCRB_BIT_FINE_STEP     4
`define SCRB_SEL_MSB           3
`define SCRB_SEL_LSB           0
`define SCRB_BIT_CLK_PECL      2
`define SCRB_BIT_SREF_PECL     1
`define SCRB_BIT_INVERT        0
`define SCRB_BIT_QUANT_QUIET   2
`define SCRB_BIT_CLK_QUIET     0
`define SCRB_POS_W             24
`endif

//--- design/scrb_sync.v
// Purpose: Two-flop synchroniser for a bus of independent level bits
// Assumes: Each bit changes slowly relative to sys_clk
// Notes:   First stage is read only by the second stage
`timescale 1ns/1ps
module scrb_sync #(
   parameter WIDTH = 24
) (
   input  wire             sys_clk,
   input  wire             reset,
   input  wire [WIDTH-1:0] async_in,
   output reg  [WIDTH-1:0] sync_out
);
   reg [WIDTH-1:0] stage1;
   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         stage1   <= {WIDTH{1'b0}};
         sync_out <= {WIDTH{1'b0}};
      end else begin
         stage1   <= async_in;
         sync_out <= stage1;
      end
   end
endmodule

//--- design/scrb_regs.v
// Purpose: Alignment and clock conditioning control register bank
// Assumes: Serial decoder presents address, write strobe and read strobe
//          on sys_clk; edge position status arrives from the analog side
// Notes:   All control outputs come straight from register flops; status
//          bytes are read one at a time with no snapshot, so a status word
//          that moves between reads can tear
`timescale 1ns/1ps
`include "scrb_consts.vh"
module scrb_regs #(
   parameter POS_W = `SCRB_POS_W
) (
   input  wire                     sys_clk,
   input  wire                     reset,
   input  wire [`SCRB_ADDR_W-1:0]  reg_addr,
   input  wire                     reg_write,
   input  wire [`SCRB_DATA_W-1:0]  reg_wdata,
   input  wire                     reg_read,
   output reg  [`SCRB_DATA_W-1:0]  reg_rdata,
   output reg                      reg_rvalid,
   input  wire [POS_W-1:0]         edge_position_in,
   output reg                      alignment_processor_enable,
   output reg                      alignment_receiver_enable,
   output reg                      window_fine_step,
   output reg  [3:0]               alignment_delay_select,
   output reg                      alignment_polarity_invert,
   output reg                      clock_input_pecl_mode,
   output reg                      alignment_input_pecl_mode,
   output reg                      quantizer_supply_quieting,
   output reg                      clock_supply_quieting
);
   // Stored register images and their next values
   reg  [`SCRB_DATA_W-1:0] alignment_control;
   reg  [`SCRB_DATA_W-1:0] clock_input_control;
   reg  [`SCRB_DATA_W-1:0] supply_quieting_control;
   reg  [`SCRB_DATA_W-1:0] next_alignment_control;
   reg  [`SCRB_DATA_W-1:0] next_clock_input_control;
   reg  [`SCRB_DATA_W-1:0] next_supply_quieting_control;
   reg  [`SCRB_DATA_W-1:0] next_rdata;
   wire [POS_W-1:0]        alignment_edge_position;

   // Address decode; control hits feed the store and the read mux, status hits only the read mux
   wire                    hit_align;
   wire                    hit_clk_in;
   wire                    hit_supply;
   wire                    hit_pos_lo;
   wire                    hit_pos_mid;
   wire                    hit_pos_hi;

   // Named fields of the stored images
   wire                    field_proc_en;
   wire                    field_recv_en;
   wire                    field_fine_step;
   wire [3:0]              field_delay_sel;
   wire                    field_invert;
   wire                    field_clk_pecl;
   wire                    field_sref_pecl;
   wire                    field_quant_quiet;
   wire                    field_clk_quiet;

   // Status comes from another domain
   scrb_sync #(
      .WIDTH (POS_W)
   ) u_pos_sync (
      .sys_clk  (sys_clk),
      .reset    (reset),
      .async_in (edge_position_in),
      .sync_out (alignment_edge_position)
   );

   assign hit_align   = (reg_addr == `SCRB_OFF_ALIGN_CTRL);
   assign hit_clk_in  = (reg_addr == `SCRB_OFF_CLK_IN_CTRL);
   assign hit_supply  = (reg_addr == `SCRB_OFF_SUPPLY_CTRL);
   assign hit_pos_lo  = (reg_addr == `SCRB_OFF_POS_LO);
   assign hit_pos_mid = (reg_addr == `SCRB_OFF_POS_MID);
   assign hit_pos_hi  = (reg_addr == `SCRB_OFF_POS_HI);

   // A write lands in its image at the strobe edge
   // Reserved bits are stored as written; host keeps them at reset value
   always @* begin
      next_alignment_control = alignment_control;
      if (reg_write && hit_align) begin
         next_alignment_control = reg_wdata;
      end
   end

   always @* begin
      next_clock_input_control = clock_input_control;
      if (reg_write && hit_clk_in) begin
         next_clock_input_control = reg_wdata;
      end
   end

   // Status offsets have no image, so writes to them are dropped
   always @* begin
      next_supply_quieting_control = supply_quieting_control;
      if (reg_write && hit_supply) begin
         next_supply_quieting_control = reg_wdata;
      end
   end

   // Images hold their reset values while reset is high
   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         alignment_control <= `SCRB_RST_ALIGN_CTRL;
      end else begin
         alignment_control <= next_alignment_control;
      end
   end

   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         clock_input_control <= `SCRB_RST_CLK_IN_CTRL;
      end else begin
         clock_input_control <= next_clock_input_control;
      end
   end

   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         supply_quieting_control <= `SCRB_RST_SUPPLY_CTRL;
      end else begin
         supply_quieting_control <= next_supply_quieting_control;
      end
   end

   // Field slices of the images
   assign field_proc_en     = alignment_control[`SCRB_BIT_PROC_EN];
   assign field_recv_en     = alignment_control[`SCRB_BIT_RECV_EN];
   assign field_fine_step   = alignment_control[`SCRB_BIT_FINE_STEP];
   assign field_delay_sel   = alignment_control[`SCRB_SEL_MSB:`SCRB_SEL_LSB];
   assign field_invert      = clock_input_control[`SCRB_BIT_INVERT];
   assign field_clk_pecl    = clock_input_control[`SCRB_BIT_CLK_PECL];
   assign field_sref_pecl   = clock_input_control[`SCRB_BIT_SREF_PECL];
   assign field_quant_quiet = supply_quieting_control[`SCRB_BIT_QUANT_QUIET];
   assign field_clk_quiet   = supply_quieting_control[`SCRB_BIT_CLK_QUIET];

   // One stage between image and output keeps every output a plain flop;
   // a written field shows one edge after its strobe edge
   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         alignment_processor_enable <= 1'b0;
         alignment_receiver_enable  <= 1'b0;
         window_fine_step           <= 1'b0;
         alignment_delay_select     <= 4'h0;
      end else begin
         alignment_processor_enable <= field_proc_en;
         alignment_receiver_enable  <= field_recv_en;
         window_fine_step           <= field_fine_step;
         alignment_delay_select     <= field_delay_sel;
      end
   end

   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         alignment_polarity_invert <= 1'b0;
         clock_input_pecl_mode     <= 1'b0;
         alignment_input_pecl_mode <= 1'b0;
      end else begin
         alignment_polarity_invert <= field_invert;
         clock_input_pecl_mode     <= field_clk_pecl;
         alignment_input_pecl_mode <= field_sref_pecl;
      end
   end

   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         quantizer_supply_quieting <= 1'b0;
         clock_supply_quieting     <= 1'b0;
      end else begin
         quantizer_supply_quieting <= field_quant_quiet;
         clock_supply_quieting     <= field_clk_quiet;
      end
   end

   // Unmapped offsets read as zero; a same-cycle write is not yet seen
   always @* begin
      next_rdata = 8'h00;
      if (hit_align) begin
         next_rdata = alignment_control;
      end else if (hit_clk_in) begin
         next_rdata = clock_input_control;
      end else if (hit_supply) begin
         next_rdata = supply_quieting_control;
      end else if (hit_pos_lo) begin
         next_rdata = alignment_edge_position[7:0];
      end else if (hit_pos_mid) begin
         next_rdata = alignment_edge_position[15:8];
      end else if (hit_pos_hi) begin
         next_rdata = alignment_edge_position[23:16];
      end
   end

   // Read data holds between reads; the valid flag follows the read strobe one edge later
   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         reg_rvalid <= 1'b0;
      end else begin
         reg_rvalid <= reg_read;
      end
   end

   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         reg_rdata <= 8'h00;
      end else if (reg_read) begin
         reg_rdata <= next_rdata;
      end
   end
endmodule

//--- verif/scrb_host.sv
// Purpose: Host model issuing register writes and reads
// Assumes: Strobes are taken at the rising edge of sys_clk
// Notes:   Released address and data lines show inverted last values
`timescale 1ns/1ps
module scrb_host (
   input  wire         sys_clk,
   input  wire  [7:0]  reg_rdata,
   output logic        reg_write,
   output logic        reg_read,
   output logic [7:0]  reg_wdata,
   output logic [15:0] reg_addr
);
   initial {reg_write, reg_read, reg_wdata, reg_addr} = 26'h0;
   task wr(input [15:0] a, input [7:0] d);
      @(negedge sys_clk);
      {reg_addr, reg_wdata, reg_write} = {a, d, 1'b1};
      @(negedge sys_clk);
      {reg_addr, reg_wdata, reg_write} = {~a, ~d, 1'b0};
   endtask
   task rd(input [15:0] a, output [7:0] d);
      @(negedge sys_clk);
      {reg_addr, reg_read} = {a, 1'b1};
      @(negedge sys_clk);
      {reg_addr, reg_read} = {~a, 1'b0};
      d = reg_rdata;
   endtask
   // Receiver first, processor second, reserved bit kept high
   task align(input [6:0] f);
      wr(16'h0029, {3'b101, f[4:0]});
      wr(16'h0029, {1'b1, f});
   endtask
endmodule

//--- verif/scrb_regs_sva.sv
// Purpose: Output timing checks for the register bank
// Assumes: Fields show one edge after the write strobe edge, checked at the second
// Notes:   Bound to every register bank instance
`timescale 1ns/1ps
module scrb_chk (
   input wire        sys_clk,
   input wire        reset,
   input wire [15:0] reg_addr,
   input wire        reg_write,
   input wire [7:0]  reg_wdata,
   input wire        alignment_processor_enable,
   input wire        alignment_receiver_enable,
   input wire        window_fine_step,
   input wire [3:0]  alignment_delay_select,
   input wire        alignment_polarity_invert,
   input wire        clock_input_pecl_mode,
   input wire        alignment_input_pecl_mode,
   input wire        quantizer_supply_quieting,
   input wire        clock_supply_quieting
);
   logic [7:0] d1, d2;
   logic [2:0] s1, s2;
   wire  [6:0] al = {alignment_processor_enable, alignment_receiver_enable,
                     window_fine_step, alignment_delay_select};
   wire  [2:0] ck = {clock_input_pecl_mode, alignment_input_pecl_mode,
                     alignment_polarity_invert};
   wire  [1:0] sq = {quantizer_supply_quieting, clock_supply_quieting};
   wire  [2:0] hit = {3{reg_write}} & {reg_addr == 16'h002b,
                     reg_addr == 16'h002a, reg_addr == 16'h0029};
   default clocking @(posedge sys_clk); endclocking
   default disable iff (reset);
   always @(posedge sys_clk or posedge reset)
      if (reset) {s1, s2} <= 6'h00;
      else {s1, s2, d1, d2} <= {hit, s1, reg_wdata, d1};
   a_proc_en: assert property (s2[0] |-> al[6] == d2[6])
      else $error("processor enable wrong");
   a_recv_en: assert property (s2[0] |-> al[5] == d2[5])
      else $error("receiver enable wrong");
   a_fine_step: assert property (s2[0] |-> al[4] == d2[4])
      else $error("fine step wrong");
   a_delay_sel: assert property (s2[0] |-> al[3:0] == d2[3:0])
      else $error("delay select wrong");
   a_pol_inv: assert property (s2[1] |-> ck[0] == d2[0])
      else $error("polarity invert wrong");
   a_clk_pecl: assert property (s2[1] |-> ck[2] == d2[2])
      else $error("clock pecl mode wrong");
   a_sref_pecl: assert property (s2[1] |-> ck[1] == d2[1])
      else $error("alignment pecl mode wrong");
   a_quiet_bits: assert property (s2[2] |-> sq == {d2[2], d2[0]})
      else $error("supply quieting wrong");
endmodule
bind scrb_regs scrb_chk i_chk (
   .sys_clk                    (sys_clk),
   .reset                      (reset),
   .reg_addr                   (reg_addr),
   .reg_write                  (reg_write),
   .reg_wdata                  (reg_wdata),
   .alignment_processor_enable (alignment_processor_enable),
   .alignment_receiver_enable  (alignment_receiver_enable),
   .window_fine_step           (window_fine_step),
   .alignment_delay_select     (alignment_delay_select),
   .alignment_polarity_invert  (alignment_polarity_invert),
   .clock_input_pecl_mode      (clock_input_pecl_mode),
   .alignment_input_pecl_mode  (alignment_input_pecl_mode),
   .quantizer_supply_quieting  (quantizer_supply_quieting),
   .clock_supply_quieting      (clock_supply_quieting)
);

//--- verif/tb_top.sv
// Purpose: Directed test of the register bank through the host model
// Assumes: Status input held long enough to pass the synchroniser
// Notes:   Inputs move on the falling edge
`timescale 1ns/1ps
`define CHK(w, e, g) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
$display("ERROR %s exp %h got %h", w, e, g); end end
module tb_top;
   logic        sys_clk = 1'b0;
   logic        reset = 1'b1;
   logic        reg_write, reg_read, reg_rvalid;
   logic [15:0] reg_addr;
   logic [7:0]  reg_wdata, reg_rdata, v;
   logic [7:0]  rst [3] = '{8'h80, 8'h00, 8'h10};
   logic [23:0] edge_position_in = 24'ha5_c31e;
   logic [3:0]  alignment_delay_select;
   logic        alignment_processor_enable, alignment_receiver_enable;
   logic        window_fine_step, alignment_polarity_invert;
   logic        clock_input_pecl_mode, alignment_input_pecl_mode;
   logic        quantizer_supply_quieting, clock_supply_quieting;
   int          n_fail = 0;
   int          n_checks = 0;
   wire  [11:0] outs = {alignment_processor_enable, alignment_receiver_enable,
      window_fine_step, alignment_delay_select, clock_input_pecl_mode,
      alignment_input_pecl_mode, alignment_polarity_invert,
      quantizer_supply_quieting, clock_supply_quieting};
   scrb_regs i_dut (
      .sys_clk                    (sys_clk),
      .reset                      (reset),
      .reg_addr                   (reg_addr),
      .reg_write                  (reg_write),
      .reg_wdata                  (reg_wdata),
      .reg_read                   (reg_read),
      .reg_rdata                  (reg_rdata),
      .reg_rvalid                 (reg_rvalid),
      .edge_position_in           (edge_position_in),
      .alignment_processor_enable (alignment_processor_enable),
      .alignment_receiver_enable  (alignment_receiver_enable),
      .window_fine_step           (window_fine_step),
      .alignment_delay_select     (alignment_delay_select),
      .alignment_polarity_invert  (alignment_polarity_invert),
      .clock_input_pecl_mode      (clock_input_pecl_mode),
      .alignment_input_pecl_mode  (alignment_input_pecl_mode),
      .quantizer_supply_quieting  (quantizer_supply_quieting),
      .clock_supply_quieting      (clock_supply_quieting)
   );
   scrb_host i_host (
      .sys_clk   (sys_clk),
      .reg_rdata (reg_rdata),
      .reg_write (reg_write),
      .reg_read  (reg_read),
      .reg_wdata (reg_wdata),
      .reg_addr  (reg_addr)
   );
   always #2.5 sys_clk = ~sys_clk;
   task end_of_test;
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      #20000;
      n_fail++;
      end_of_test;
   end
   initial begin
      repeat (4) @(negedge sys_clk);
      reset = 1'b0;
      `CHK("reset outputs", 12'h000, outs)
      for (int i = 0; i < 3; i++) begin
         i_host.rd(16'(16'h0029 + i), v);
         `CHK("reset value", rst[i], v)
         i_host.rd(16'(16'h002e - i), v);
         `CHK("status byte", edge_position_in[8*(2-i) +: 8], v)
         `CHK("read valid", 1'b1, reg_rvalid)
      end
      i_host.wr(16'h002c, 8'hff);
      `CHK("valid pulse", 1'b0, reg_rvalid)
      i_host.rd(16'h002c, v);
      `CHK("status read only", 8'h1e, v)
      i_host.align({3'b111, v[3:0]});
      @(negedge sys_clk);
      `CHK("align fields", 7'h7e, outs[11:5])
      for (int i = 0; i < 3; i++) begin
         i_host.wr(16'h002a, 8'h01 << i);
         @(negedge sys_clk);
         `CHK("clock input bits", 3'h1 << i, outs[4:2])
      end
      for (int i = 0; i < 2; i++) begin
         i_host.wr(16'h002b, 8'h10 | (8'h01 << 2 * i));
         @(negedge sys_clk);
         `CHK("quieting bits", 2'h1 << i, outs[1:0])
      end
      i_host.rd(16'h002b, v);
      `CHK("quieting readback", 8'h14, v)
      i_host.rd(16'h0029, v);
      `CHK("align readback", 8'hfe, v)
      i_host.rd(16'h0030, v);
      `CHK("unmapped read", 8'h00, v)
      `CHK("held outputs", 12'hfd2, outs)
      // A moved status word shows after the two synchroniser stages
      edge_position_in = 24'h3c_5a69;
      @(negedge sys_clk);
      i_host.rd(16'h002d, v);
      `CHK("status update", 8'h5a, v)
      reset = 1'b1;
      @(negedge sys_clk);
      reset = 1'b0;
      `CHK("mid-run reset", 12'h000, outs)
      i_host.rd(16'h0029, v);
      `CHK("align after reset", 8'h80, v)
      end_of_test;
   end
endmodule
